//--- design/tcs_alarm.sv
/*
  tcs_alarm: trip circuit watch and current-input supervision alarm.
  assumes opto inputs asynchronous to i_ref_clk; comparator flags synchronous.
*/
`timescale 1ns/1ps
module tcs_alarm
  import tcs_pkg::*;
#(
  parameter int unsigned DROP_OFF_CYCLES = DROP_OFF_CYC,
  parameter int unsigned PICK_UP_CYCLES = PICK_UP_CYC,
  parameter int unsigned SUP_DELAY_DEFAULT = SUP_DELAY_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire tcs_watch_in_t i_watch,
  input wire logic i_two_input,
  input wire logic i_indicator_reset,
  input wire logic i_resid_current_high,
  input wire logic i_resid_voltage_high,
  input wire logic i_sup_enable,
  input wire logic [CNT_W-1:0] i_sup_delay,
  output tcs_watch_out_t o_watch,
  output tcs_breaker_t o_breaker,
  output logic o_sup_alarm
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] pin_raw;
  wire [1:0] pin_filt;
  logic in_a_q;
  logic in_b_q;
  assign pin_raw = {i_watch.in_b, i_watch.in_a};
  // three stages per pin, change taken once stages two and three agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [2:0] sync_q;
    logic filt_q;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        sync_q <= SYNC_RST;
        filt_q <= 1'b0;
      end else begin
        sync_q <= {sync_q[1:0], pin_raw[g]};
        if (sync_q[1] == sync_q[2]) begin
          filt_q <= sync_q[2];
        end
      end
    end
    assign pin_filt[g] = filt_q;
  end
  assign in_a_q = pin_filt[0];
  assign in_b_q = pin_filt[1];
  logic timer_in;
  assign timer_in = i_two_input ? (in_a_q | in_b_q) : in_a_q;
  // ----------------------------------------
  // counter end decode
  // ----------------------------------------
  function automatic logic cnt_done(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] last
  );
    return (cnt >= last);
  endfunction
  // ----------------------------------------
  // drop-off delay timer
  // ----------------------------------------
  logic [CNT_W-1:0] drop_cnt_q;
  logic drop_q;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      drop_cnt_q <= CNT_ZERO;
      drop_q <= 1'b0;
    end else if (timer_in) begin
      drop_cnt_q <= CNT_ZERO;
      drop_q <= 1'b1;
    end else if (drop_q) begin
      if (cnt_done(drop_cnt_q, CNT_W'(DROP_OFF_CYCLES - 1))) begin
        drop_q <= 1'b0;
        drop_cnt_q <= CNT_ZERO;
      end else begin
        drop_cnt_q <= drop_cnt_q + 1'b1;
      end
    end
  end
  // ----------------------------------------
  // pick-up delay and alarms
  // ----------------------------------------
  logic [CNT_W-1:0] pick_cnt_q;
  logic fail_q;
  logic ind_q;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pick_cnt_q <= CNT_ZERO;
      fail_q <= 1'b0;
    end else if (drop_q) begin
      pick_cnt_q <= CNT_ZERO;
      fail_q <= 1'b0;
    end else if (cnt_done(pick_cnt_q, CNT_W'(PICK_UP_CYCLES - 1))) begin
      fail_q <= 1'b1;
    end else begin
      pick_cnt_q <= pick_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ind_q <= 1'b0;
    end else if (drop_q) begin
      ind_q <= 1'b0;
    end else if (fail_q) begin
      ind_q <= 1'b1;
    end else if (i_indicator_reset) begin
      ind_q <= 1'b0;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_watch <= '0;
      o_breaker <= '0;
    end else begin
      o_watch.drop_off_delay <= drop_q;
      o_watch.alarm_relay_closed <= ~drop_q;
      o_watch.indicator <= ind_q & ~drop_q;
      o_watch.user_alarm <= fail_q & ~drop_q;
      o_breaker.breaker_closed <= i_two_input & in_a_q;
      o_breaker.breaker_open <= i_two_input & in_b_q;
    end
  end
  // ----------------------------------------
  // current-input supervision
  // ----------------------------------------
  logic sup_fault;
  logic [CNT_W-1:0] sup_cnt_q;
  logic [CNT_W-1:0] sup_limit;
  assign sup_limit = (i_sup_delay == CNT_ZERO) ? CNT_W'(SUP_DELAY_DEFAULT) : i_sup_delay;
  assign sup_fault = i_sup_enable & i_resid_current_high & ~i_resid_voltage_high;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sup_cnt_q <= CNT_ZERO;
      o_sup_alarm <= 1'b0;
    end else if (!sup_fault) begin
      sup_cnt_q <= CNT_ZERO;
      o_sup_alarm <= 1'b0;
    end else if (cnt_done(sup_cnt_q, sup_limit - 1'b1)) begin
      o_sup_alarm <= 1'b1;
    end else begin
      sup_cnt_q <= sup_cnt_q + 1'b1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_drop_rise_now: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    timer_in |=> drop_q)
    else $error("drop-off output not raised");
  a_drop_holds_low: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    $fell(drop_q) |-> $past(drop_cnt_q) == CNT_W'(DROP_OFF_CYCLES - 1))
    else $error("drop-off released early");
  a_relay_open_ok: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    drop_q |=> !o_watch.alarm_relay_closed && !o_watch.user_alarm && !o_watch.indicator)
    else $error("alarm active while healthy");
  a_relay_closed: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !drop_q && $past(i_nrst) |=> o_watch.alarm_relay_closed)
    else $error("relay open while timer low");
  a_pickup_wait: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(fail_q) |-> !$past(drop_q) && $past(pick_cnt_q) == CNT_W'(PICK_UP_CYCLES - 1))
    else $error("pick-up too early");
  a_ind_latch: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ind_q && !drop_q && !i_indicator_reset |=> ind_q)
    else $error("indicator lost latch");
  a_ind_reset_refused: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    fail_q && !drop_q |=> ind_q)
    else $error("indicator not set on failure");
  a_or_inputs: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    i_two_input && in_b_q |=> drop_q)
    else $error("input b not ored");
  a_single_input: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !i_two_input && !in_a_q && !drop_q |=> !drop_q)
    else $error("input b used in single mode");
  a_breaker_map: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ##1 o_breaker.breaker_open == ($past(i_two_input) & $past(in_b_q)))
    else $error("breaker open mismatch");
  a_breaker_closed: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ##1 o_breaker.breaker_closed == ($past(i_two_input) & $past(in_a_q)))
    else $error("breaker closed mismatch");
  a_sup_disable: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !i_sup_enable |=> !o_sup_alarm)
    else $error("disabled alarm raised");
  a_sup_delay: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(o_sup_alarm) |-> $past(sup_cnt_q) == sup_limit - 1'b1)
    else $error("supervision alarm early");
  a_sup_inhibit: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    i_resid_voltage_high |=> !o_sup_alarm)
    else $error("alarm raised under voltage inhibit");
  a_sup_clear: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !i_resid_current_high |=> !o_sup_alarm)
    else $error("alarm raised without residual current");
endmodule // tcs_alarm

//--- shared/tcs_pkg.sv
/*
  tcs_pkg: constants and carrier types for the trip circuit watch alarm.
  assumes a 250 MHz logic clock; all times derived to cycle counts here.
*/
package tcs_pkg;
  // ----------------------------------------
  // clock and times
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned DROP_OFF_MS = 400;
  localparam int unsigned PICK_UP_MS = 50;
  localparam int unsigned SUP_DELAY_S = 5;
  localparam int unsigned DROP_OFF_CYC = CLK_HZ / 1000 * DROP_OFF_MS;
  localparam int unsigned PICK_UP_CYC = CLK_HZ / 1000 * PICK_UP_MS;
  localparam int unsigned SUP_DELAY_CYC = CLK_HZ * SUP_DELAY_S;
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [2:0] SYNC_RST = 3'h0;
  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic in_a;
    logic in_b;
  } tcs_watch_in_t;
  typedef struct packed {
    logic drop_off_delay;
    logic alarm_relay_closed;
    logic indicator;
    logic user_alarm;
  } tcs_watch_out_t;
  typedef struct packed {
    logic breaker_closed;
    logic breaker_open;
  } tcs_breaker_t;
endpackage

//--- verif/tcs_coil_model.sv
/*
  tcs_coil_model: trip coil wiring seen through two supervision inputs.
  assumes the bench drives breaker position and coil health as levels.
*/
`timescale 1ns/1ps
module tcs_coil_model
  import tcs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_cb_closed,
  input wire logic i_coil_ok,
  output tcs_watch_in_t o_watch
);
  // closed breaker feeds input a, open breaker feeds b, broken coil starves both
  always_ff @(posedge i_ref_clk) begin
    o_watch.in_a <= i_coil_ok & i_cb_closed;
    o_watch.in_b <= i_coil_ok & ~i_cb_closed;
  end
endmodule // tcs_coil_model

//--- verif/tb_top.sv
/*
  tb_top: self-checking bench for tcs_alarm with short timer parameters.
  assumes tcs_coil_model drives the supervision inputs.
*/
`timescale 1ns/1ps
module tb_top;
  import tcs_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic two = 1'b0;
  logic cb_closed = 1'b0;
  logic coil_ok = 1'b1;
  logic ind_rst = 1'b0;
  logic cur = 1'b0;
  logic volt = 1'b1;
  logic sup_en = 1'b0;
  logic [CNT_W-1:0] dly = 32'h0000_000A;
  tcs_watch_in_t pins;
  tcs_watch_out_t wo;
  tcs_breaker_t bo;
  logic sup;
  logic [6:0] exp_q[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  int d;
  event chk_ev;
  always #2 clk = ~clk;
  tcs_coil_model model_u (.i_ref_clk(clk), .i_cb_closed(cb_closed), .i_coil_ok(coil_ok),
    .o_watch(pins));
  tcs_alarm #(.DROP_OFF_CYCLES(40), .PICK_UP_CYCLES(5), .SUP_DELAY_DEFAULT(20)) dut_u (
    .i_ref_clk(clk), .i_nrst(nrst), .i_watch(pins), .i_two_input(two),
    .i_indicator_reset(ind_rst), .i_resid_current_high(cur), .i_resid_voltage_high(volt),
    .i_sup_enable(sup_en), .i_sup_delay(dly), .o_watch(wo), .o_breaker(bo), .o_sup_alarm(sup));
  // ----------------------------------------
  // tasks and watcher
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(input logic [6:0] e);
    @(negedge clk);
    exp_q.push_back(e);
    ->chk_ev;
  endtask
  task automatic cmp_out(input logic [6:0] want, input logic [6:0] seen);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED outputs exp %h got %h", want, seen);
    end
  endtask
  always @(chk_ev) begin
    cmp_out(exp_q[0], {wo, bo, sup});
    void'(exp_q.pop_front());
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    final_report();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(46800));
    d = 8 + $urandom % 5;
    cyc(3);
    nrst <= 1'b1;
    cyc(2);
    note(7'h20);
    cyc(18);
    note(7'h38);
    $display("test single input done");
    @(posedge clk) two <= 1'b1;
    cyc(12);
    note(7'h42);
    @(posedge clk) cb_closed <= 1'b1;
    cyc(12);
    note(7'h44);
    @(posedge clk) coil_ok <= 1'b0;
    cyc(30);
    note(7'h40);
    cyc(30);
    note(7'h38);
    @(posedge clk) ind_rst <= 1'b1;
    cyc(4);
    note(7'h38);
    @(posedge clk) begin
      coil_ok <= 1'b1;
      ind_rst <= 1'b0;
    end
    cyc(12);
    note(7'h44);
    $display("test trip watch done");
    @(posedge clk) begin
      sup_en <= 1'b1;
      dly <= CNT_W'(d);
      cur <= 1'b1;
    end
    cyc(d + 6);
    note(7'h44);
    @(posedge clk) volt <= 1'b0;
    cyc(d - 3);
    note(7'h44);
    cyc(7);
    note(7'h45);
    @(posedge clk) sup_en <= 1'b0;
    cyc(2);
    note(7'h44);
    @(posedge clk) begin
      sup_en <= 1'b1;
      dly <= CNT_ZERO;
    end
    cyc(15);
    note(7'h44);
    cyc(10);
    note(7'h45);
    $display("test supervision done");
    cyc(2);
    final_report();
  end
endmodule // tb_top
